// ===== core/ppc_regs.svh
// register map, field positions, reset values and counts of the
// picture processor control bank.
// assumes: included by bare name from the design files and the bench.
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH

// ==========================================================================
// serial bus address and subaddresses
// ==========================================================================
`define PPC_SLAVE_ADDR      7'h15
`define PPC_SUB_MODE        8'h00
`define PPC_SUB_LEVEL       8'h01
`define PPC_SUB_LINE        8'h02
`define PPC_SUB_TEST        8'h03
`define PPC_NUM_REGS        8'h04

// ==========================================================================
// field positions
// ==========================================================================
`define PPC_OP_HI           7
`define PPC_OP_LO           6
`define PPC_FRAME_BIT       5
`define PPC_SPLIT_BIT       3
`define PPC_TAPE_BIT        2
`define PPC_DENOISE_BIT     1
`define PPC_WIDTH_BIT       0
`define PPC_GREY_HI         7
`define PPC_GREY_LO         5
`define PPC_LIMIT_HI        4
`define PPC_LIMIT_LO        0
`define PPC_ROW_HI          7
`define PPC_ROW_LO          5
`define PPC_CLASS_EN_BIT    7
`define PPC_CLASS_HI        6
`define PPC_CLASS_LO        5
`define PPC_COEF_EN_BIT     4
`define PPC_COEF_HI         3
`define PPC_COEF_LO         0

// ==========================================================================
// reset values
// ==========================================================================
`define PPC_MODE_RST        8'h00
`define PPC_ROW_DEC_RST     3'h4
`define PPC_COEF_K_RST      5'h10

// ==========================================================================
// line timing in output pixel clocks
// ==========================================================================
`define PPC_ACTIVE_PIX      11'h2D0
`define PPC_HALF_PIX        11'h168

// ==========================================================================
// synchroniser lanes
// ==========================================================================
`define PPC_SYNC_W          8
`define PPC_SI_SCL          0
`define PPC_SI_SDA          1
`define PPC_SI_REQ          2
`define PPC_SI_BLANK        3
`define PPC_SI_INCLK        4
`define PPC_SI_OUTCLK       5
`define PPC_SI_VS           6
`define PPC_SI_FMT          7
// idle levels: scl, sda and line_blank_n rest high
`define PPC_SYNC_IDLE       8'h0B

`endif

// ===== core/ppc_pkg.sv
// types shared by the picture processor control bank.
// assumes: compiled before the design modules.
package ppc_pkg;

    typedef enum logic [6:0] {
        PPC_ST_IDLE  = 7'h01,
        PPC_ST_ADDR  = 7'h02,
        PPC_ST_ACKA  = 7'h04,
        PPC_ST_SUB   = 7'h08,
        PPC_ST_ACKS  = 7'h10,
        PPC_ST_DATA  = 7'h20,
        PPC_ST_ACKD  = 7'h40
    } ppc_bus_state_t;

    typedef enum logic [1:0] {
        PPC_OP_NORMAL       = 2'h0,
        PPC_OP_MULTI        = 2'h1,
        PPC_OP_STILL_IN     = 2'h2,
        PPC_OP_PIC_IN_STILL = 2'h3
    } ppc_op_mode_t;

    typedef struct packed {
        ppc_op_mode_t op_mode;
        logic         narrow_frame;
        logic         split_screen;
        logic         tape_source_select;
        logic         denoise_switch;
        logic         input_width_sel;
        logic [2:0]   border_grey_level;
        logic [4:0]   lower_snr_limit;
        logic [4:0]   upper_snr_limit;
        logic [2:0]   measure_row;
        logic         class_force_enable;
        logic [1:0]   forced_class;
        logic         coef_force_enable;
        logic [4:0]   forced_coef_k;
    } ppc_settings_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
    } ppc_sync_st_t;

    typedef struct packed {
        ppc_bus_state_t st;
        logic [3:0]     bit_cnt;
        logic [7:0]     shreg;
        logic [7:0]     sub;
        ppc_op_mode_t   pend_mode;
        logic           pend_ff;
        ppc_settings_t  cfg;
        logic [10:0]    pix_cnt;
        logic           sda_oe;
        logic           sda_out;
        logic           nr_active;
        logic           field_start;
        logic           line_start;
        logic           in_tick;
        logic           out_tick;
        logic           chroma_low_valid;
    } ppc_ctrl_st_t;

endpackage

// ===== core/ppc_sync.sv
// two-stage synchroniser for all pin inputs, with edge pulses.
// assumes: inputs asynchronous to clk; edges taken behind the second stage.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"

module ppc_sync (
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic [`PPC_SYNC_W-1:0] raw,
    output logic      [`PPC_SYNC_W-1:0] lvl,
    output logic      [`PPC_SYNC_W-1:0] rise,
    output logic      [`PPC_SYNC_W-1:0] fall
);

    ppc_pkg::ppc_sync_st_t s_ff;
    ppc_pkg::ppc_sync_st_t nxt_s;

    always_comb begin
        nxt_s    = s_ff;
        nxt_s.s1 = raw;
        nxt_s.s2 = s_ff.s1;
        nxt_s.s3 = s_ff.s2;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // idle levels, so no false edge follows reset
            s_ff <= {3{`PPC_SYNC_IDLE}};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // stage one feeds stage two only; edges compare stages two and three
    assign lvl  = s_ff.s2;
    assign rise = s_ff.s2 & ~s_ff.s3;
    assign fall = s_ff.s3 & ~s_ff.s2;

endmodule
`default_nettype wire

// ===== core/ppc_ctrl.sv
// write-only control bank of the picture processor, loaded by a serial
// bus slave receiver, plus the strobe and pixel-clock handling around it.
// assumes: all pins asynchronous to clk; clk much faster than scl.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"

// Functional notes
// R1: split screen filters one half only
// R2: tape source bit, zero means television
// R3: denoise switch, zero means off
// R4: width bit, zero seven bits, one eight
// R5: border grey level three bits, black default
// R6: lower noise threshold five bits
// R7: upper noise threshold five bits
// R8: row code decodes to measurement line
// R9: class force enable selects forced class
// R10: coefficient force enable selects fixed K
// R11: internal reset loads all defaults
// R12: request plus vertical sync switches mode
// R13: blanking strobe synchronises line sequencing
// R14: input pixel clock drives input timing
// R15: output pixel clock times output data
// R16: low chroma bits valid in 4:2:2
// R17: vertical sync sets picture vertical position
// R18: subaddress advances after every data byte
// R19: multi-picture mode changes only in window
// R20: top two mode bits select operation
// R21: reserved row code falls back to default
module ppc_ctrl (
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           scl,
    input  wire logic           sda_in,
    input  wire logic           transfer_request,
    input  wire logic           line_blank_n,
    input  wire logic           input_pixel_clock,
    input  wire logic           output_pixel_clock,
    input  wire logic           vertical_sync_in,
    input  wire logic           out_fmt_422,
    output ppc_pkg::ppc_settings_t settings,
    output logic                nr_active,
    output logic                field_start,
    output logic                line_start,
    output logic                in_pix_tick,
    output logic                out_pix_tick,
    output logic                chroma_low_valid,
    output logic                sda_out,
    output logic                sda_oe
);

    // ======================================================================
    // decoders
    // ======================================================================
    function automatic logic [2:0] row_decode(input logic [2:0] code);
        logic [2:0] r;
        case (code)
            3'h0: r = 3'h4;
            3'h1: r = 3'h0;
            3'h2: r = 3'h1;
            3'h3: r = 3'h2;
            3'h4: r = 3'h3;
            3'h5: r = 3'h5;
            3'h6: r = 3'h7;
            default: r = `PPC_ROW_DEC_RST; // see R21
        endcase
        return r;
    endfunction

    // K in sixteenths
    function automatic logic [4:0] coef_decode(input logic [3:0] code);
        logic [4:0] k;
        case (code)
            4'h0: k = 5'h10;
            4'h1: k = 5'h0C;
            4'h2: k = 5'h0A;
            4'h3: k = 5'h09;
            4'h4: k = 5'h0C;
            4'h5: k = 5'h08;
            4'h6: k = 5'h06;
            4'h7: k = 5'h05;
            4'h8: k = 5'h0A;
            4'h9: k = 5'h06;
            4'hA: k = 5'h04;
            4'hB: k = 5'h03;
            4'hC: k = 5'h09;
            4'hD: k = 5'h05;
            4'hE: k = 5'h03;
            default: k = 5'h02;
        endcase
        return k;
    endfunction

    function automatic ppc_pkg::ppc_settings_t write_byte(
        input ppc_pkg::ppc_settings_t c,
        input logic [7:0]             sub,
        input logic [7:0]             d
    );
        ppc_pkg::ppc_settings_t r;
        r = c;
        case (sub)
            `PPC_SUB_MODE: begin
                r.narrow_frame       = d[`PPC_FRAME_BIT];
                r.split_screen       = d[`PPC_SPLIT_BIT];   // see R1
                r.tape_source_select = d[`PPC_TAPE_BIT];    // see R2
                r.denoise_switch     = d[`PPC_DENOISE_BIT]; // see R3
                r.input_width_sel    = d[`PPC_WIDTH_BIT];   // see R4
            end
            `PPC_SUB_LEVEL: begin
                r.border_grey_level = d[`PPC_GREY_HI:`PPC_GREY_LO];   // see R5
                r.lower_snr_limit   = d[`PPC_LIMIT_HI:`PPC_LIMIT_LO]; // see R6
            end
            `PPC_SUB_LINE: begin
                r.measure_row     = row_decode(d[`PPC_ROW_HI:`PPC_ROW_LO]);
                r.upper_snr_limit = d[`PPC_LIMIT_HI:`PPC_LIMIT_LO]; // see R7
            end
            `PPC_SUB_TEST: begin
                r.class_force_enable = d[`PPC_CLASS_EN_BIT];        // see R9
                r.forced_class       = d[`PPC_CLASS_HI:`PPC_CLASS_LO];
                r.coef_force_enable  = d[`PPC_COEF_EN_BIT];         // see R10
                r.forced_coef_k = coef_decode(d[`PPC_COEF_HI:`PPC_COEF_LO]);
            end
            default: r = c;
        endcase
        return r;
    endfunction

    // ======================================================================
    // pin synchronisers
    // ======================================================================
    logic [`PPC_SYNC_W-1:0] lvl;
    logic [`PPC_SYNC_W-1:0] rise;
    logic [`PPC_SYNC_W-1:0] fall;

    ppc_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .raw     ({out_fmt_422, vertical_sync_in, output_pixel_clock,
                   input_pixel_clock, line_blank_n, transfer_request,
                   sda_in, scl}),
        .lvl     (lvl),
        .rise    (rise),
        .fall    (fall)
    );

    // ======================================================================
    // state
    // ======================================================================
    ppc_pkg::ppc_ctrl_st_t s_ff;
    ppc_pkg::ppc_ctrl_st_t nxt_s;
    logic                  bus_start;
    logic                  bus_stop;
    logic                  byte_end;
    logic                  mp_gated;
    logic                  vs_window;

    assign bus_start = lvl[`PPC_SI_SCL] & fall[`PPC_SI_SDA];
    assign bus_stop  = lvl[`PPC_SI_SCL] & rise[`PPC_SI_SDA];
    assign byte_end  = fall[`PPC_SI_SCL] & (s_ff.bit_cnt == 4'h8);
    assign mp_gated  = (s_ff.cfg.op_mode == ppc_pkg::PPC_OP_MULTI) |
                       (s_ff.pend_mode == ppc_pkg::PPC_OP_MULTI);
    assign vs_window = lvl[`PPC_SI_VS] & lvl[`PPC_SI_REQ];

    always_comb begin
        nxt_s             = s_ff;
        nxt_s.sda_out     = 1'b0;
        nxt_s.field_start = rise[`PPC_SI_VS];             // see R17
        nxt_s.line_start  = rise[`PPC_SI_BLANK];          // see R13
        nxt_s.in_tick     = rise[`PPC_SI_INCLK];          // see R14
        nxt_s.out_tick    = rise[`PPC_SI_OUTCLK];         // see R15
        nxt_s.chroma_low_valid = lvl[`PPC_SI_FMT];        // see R16

        // pixel position in the active line, counted on output clock
        if (rise[`PPC_SI_BLANK]) begin
            nxt_s.pix_cnt = 11'h000;                      // see R13
        end else if (rise[`PPC_SI_OUTCLK] && lvl[`PPC_SI_BLANK] &&
                     s_ff.pix_cnt != `PPC_ACTIVE_PIX) begin
            nxt_s.pix_cnt = s_ff.pix_cnt + 11'h001;       // see R15
        end
        nxt_s.nr_active = s_ff.cfg.denoise_switch &&      // see R3
            !(s_ff.cfg.split_screen &&
              s_ff.pix_cnt >= `PPC_HALF_PIX);             // see R1

        // mode switch; multi-picture waits for the sync window
        if (s_ff.pend_ff && (!mp_gated || vs_window)) begin // see R19
            nxt_s.cfg.op_mode = s_ff.pend_mode;           // see R12
            nxt_s.pend_ff     = 1'b0;
        end

        if (bus_start) begin
            nxt_s.st      = ppc_pkg::PPC_ST_ADDR;
            nxt_s.bit_cnt = 4'h0;
            nxt_s.sda_oe  = 1'b0;
        end else if (bus_stop) begin
            nxt_s.st     = ppc_pkg::PPC_ST_IDLE;
            nxt_s.sda_oe = 1'b0;
        end else begin
            case (s_ff.st)
                ppc_pkg::PPC_ST_IDLE: begin
                    nxt_s.sda_oe = 1'b0;
                end
                ppc_pkg::PPC_ST_ADDR,
                ppc_pkg::PPC_ST_SUB,
                ppc_pkg::PPC_ST_DATA: begin
                    if (rise[`PPC_SI_SCL]) begin
                        nxt_s.shreg   = {s_ff.shreg[6:0], lvl[`PPC_SI_SDA]};
                        nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
                    end else if (byte_end) begin
                        nxt_s.sda_oe = 1'b1;
                        if (s_ff.st == ppc_pkg::PPC_ST_ADDR) begin
                            // only a write to our address is acknowledged
                            if (s_ff.shreg[7:1] == `PPC_SLAVE_ADDR &&
                                !s_ff.shreg[0]) begin
                                nxt_s.st = ppc_pkg::PPC_ST_ACKA;
                            end else begin
                                nxt_s.st     = ppc_pkg::PPC_ST_IDLE;
                                nxt_s.sda_oe = 1'b0;
                            end
                        end else if (s_ff.st == ppc_pkg::PPC_ST_SUB) begin
                            nxt_s.sub = s_ff.shreg;
                            nxt_s.st  = ppc_pkg::PPC_ST_ACKS;
                        end else begin
                            nxt_s.cfg = write_byte(nxt_s.cfg, s_ff.sub,
                                                   s_ff.shreg);
                            if (s_ff.sub == `PPC_SUB_MODE) begin
                                // a fresh write beats a same-cycle apply
                                nxt_s.pend_mode = ppc_pkg::ppc_op_mode_t'(
                                    s_ff.shreg[`PPC_OP_HI:`PPC_OP_LO]);
                                nxt_s.pend_ff = 1'b1;         // see R20
                            end
                            nxt_s.sub = s_ff.sub + 8'h01;     // see R18
                            nxt_s.st  = ppc_pkg::PPC_ST_ACKD;
                        end
                    end
                end
                ppc_pkg::PPC_ST_ACKA,
                ppc_pkg::PPC_ST_ACKS,
                ppc_pkg::PPC_ST_ACKD: begin
                    if (fall[`PPC_SI_SCL]) begin
                        nxt_s.sda_oe  = 1'b0;
                        nxt_s.bit_cnt = 4'h0;
                        nxt_s.st = (s_ff.st == ppc_pkg::PPC_ST_ACKA) ?
                                   ppc_pkg::PPC_ST_SUB :
                                   ppc_pkg::PPC_ST_DATA;
                    end
                end
                default: begin
                    nxt_s.st     = ppc_pkg::PPC_ST_IDLE;
                    nxt_s.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_ff                   <= '0;                 // see R11
            s_ff.st                <= ppc_pkg::PPC_ST_IDLE;
            s_ff.cfg.measure_row   <= `PPC_ROW_DEC_RST;   // see R8
            s_ff.cfg.forced_coef_k <= `PPC_COEF_K_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign settings         = s_ff.cfg;
    assign nr_active        = s_ff.nr_active;
    assign field_start      = s_ff.field_start;
    assign line_start       = s_ff.line_start;
    assign in_pix_tick      = s_ff.in_tick;
    assign out_pix_tick     = s_ff.out_tick;
    assign chroma_low_valid = s_ff.chroma_low_valid;
    assign sda_out          = s_ff.sda_out;
    assign sda_oe           = s_ff.sda_oe;

    // ======================================================================
    // assertions
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence data_byte_s;
        s_ff.st == ppc_pkg::PPC_ST_DATA && byte_end && !bus_start &&
        !bus_stop;
    endsequence

    sequence ack_held_s;
        s_ff.sda_oe && s_ff.st == ppc_pkg::PPC_ST_ACKD;
    endsequence

    data_ack_a: assert property (data_byte_s |=> ack_held_s) // see R18
        else $error("data byte not acknowledged");

    sub_advance_a: assert property (data_byte_s |=>          // see R18
        s_ff.sub == $past(s_ff.sub) + 8'h01)
        else $error("subaddress did not advance");

    split_half_a: assert property (s_ff.cfg.split_screen &&  // see R1
        s_ff.pix_cnt >= `PPC_HALF_PIX |=> !s_ff.nr_active)
        else $error("filtering on the bypassed half");

    denoise_off_a: assert property (!s_ff.cfg.denoise_switch // see R3
        |=> !s_ff.nr_active)
        else $error("filter active while switched off");

    mode_hold_a: assert property (s_ff.pend_ff && mp_gated && // see R19
        !vs_window |=> s_ff.cfg.op_mode == $past(s_ff.cfg.op_mode))
        else $error("multi-picture mode changed outside window");

    mode_apply_a: assert property (s_ff.pend_ff && vs_window // see R12
        |=> s_ff.cfg.op_mode == $past(s_ff.pend_mode))
        else $error("pending mode not applied");

    row_reserved_a: assert property (                        // see R21
        s_ff.cfg.measure_row != 3'h6)
        else $error("measurement row outside decoded set");

    field_pulse_a: assert property (rise[`PPC_SI_VS]        // see R17
        |=> s_ff.field_start ##1 !s_ff.field_start)
        else $error("field start pulse wrong");

    line_restart_a: assert property (rise[`PPC_SI_BLANK]    // see R13
        |=> s_ff.line_start && s_ff.pix_cnt == 11'h000)
        else $error("pixel count not restarted at line start");

    chroma_low_a: assert property (##1 s_ff.chroma_low_valid // see R16
        == $past(lvl[`PPC_SI_FMT]))
        else $error("chroma low flag does not follow format");

endmodule
`default_nettype wire

// ===== testbench/ppc_i2c_mst.sv
// serial bus master model that writes telegrams to the control bank.
// assumes: sda is a wired-and with a pull-up outside this model.
`timescale 1ns/1ps
`default_nettype none

module ppc_i2c_mst (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // data moves only mid-low, so no false start or stop is seen
    task automatic put_bit(input logic v, output logic seen);
        wait_clk(4);
        sda_drv = v;
        wait_clk(4);
        scl = 1'b1;
        wait_clk(8);
        seen = sda_line;
        scl = 1'b0;
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], seen);
        end
        put_bit(1'b1, seen);
        ack = ~seen;
    endtask

    // later bytes rely on the bank stepping its subaddress
    task automatic write(input logic [6:0] addr, input logic [7:0] sub,
                         input logic [7:0] d [4], input int n,
                         output logic ok);
        logic a;
        wait_clk(4);
        sda_drv = 1'b0;
        wait_clk(8);
        scl = 1'b0;
        send({addr, 1'b0}, ok);
        send(sub, a);
        for (int i = 0; i < n; i++) begin
            send(d[i], a);
        end
        wait_clk(4);
        sda_drv = 1'b0;
        wait_clk(4);
        scl = 1'b1;
        wait_clk(8);
        sda_drv = 1'b1;
        wait_clk(8);
    endtask
endmodule

`default_nettype wire

// ===== testbench/tb_top.sv
// bench for the control bank: telegrams, mode window, strobes, pixels.
// assumes: core package and register header compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.svh"

module tb_top;
    logic clk, sys_rst, req, blank_n, ipc, opc, vs, fmt, ok;
    logic scl, sda_drv, sda_oe, nr, fs, ls, it, ot, clv, sdo;
    ppc_pkg::ppc_settings_t st;
    wire sda_line = sda_drv & ~sda_oe;
    int err_total, checks, cycles, n_line, n_field, n_in, n_out;
    logic [7:0] rows [8] = '{8'h4, 8'h0, 8'h1, 8'h2, 8'h3, 8'h5, 8'h7, 8'h4};
    logic [7:0] kt [16] = '{8'h10, 8'h0C, 8'h0A, 8'h09, 8'h0C, 8'h08,
        8'h06, 8'h05, 8'h0A, 8'h06, 8'h04, 8'h03, 8'h09, 8'h05, 8'h03, 8'h02};

    ppc_i2c_mst mst (.clk(clk), .sda_line(sda_line), .scl(scl),
                     .sda_drv(sda_drv));
    ppc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .scl(scl),
        .sda_in(sda_line), .transfer_request(req), .line_blank_n(blank_n),
        .input_pixel_clock(ipc), .output_pixel_clock(opc),
        .vertical_sync_in(vs), .out_fmt_422(fmt), .settings(st),
        .nr_active(nr), .field_start(fs), .line_start(ls),
        .in_pix_tick(it), .out_pix_tick(ot), .chroma_low_valid(clv),
        .sda_out(sdo), .sda_oe(sda_oe));

    // ==================================================================
    // clocks and pulse counters
    // ==================================================================
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // pixel clocks: 8 clk per period, phases unrelated to clk
    initial begin
        ipc = 1'b0;
        #37;
        forever #200 ipc = ~ipc;
    end
    initial begin
        opc = 1'b0;
        #111;
        forever #200 opc = ~opc;
    end
    always @(posedge clk) begin
        n_line  += int'(ls);
        n_field += int'(fs);
        n_in    += int'(it);
        n_out   += int'(ot);
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            print_verdict();
        end
    end

    // ==================================================================
    // helpers
    // ==================================================================
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input string what, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask

    task automatic wr(input logic [7:0] sub, input logic [7:0] d [4],
                      input int n);
        mst.write(`PPC_SLAVE_ADDR, sub, d, n, ok);
        check("ack", 8'(ok), 8'h01);
        tick(6);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==================================================================
    // tests
    // ==================================================================
    initial begin
        {sys_rst, req, vs, fmt, blank_n} = 5'b10001;
        tick(12);
        sys_rst = 1'b0;
        tick(6);
        check("op_mode", 8'(st.op_mode), 8'h00);
        check("row", 8'(st.measure_row), 8'h04);
        check("coef_k", 8'(st.forced_coef_k), 8'h10);
        check("grey", 8'(st.border_grey_level), 8'h00);
        check("bits", 8'({st.split_screen, st.tape_source_select,
            st.denoise_switch, st.input_width_sel, st.class_force_enable,
            st.coef_force_enable}), 8'h00);
        $display("test reset_defaults done");

        wr(8'h00, '{8'h2F, 8'hE4, 8'h10, 8'h00}, 4);
        check("bits", 8'({st.narrow_frame, st.split_screen,
            st.tape_source_select, st.denoise_switch,
            st.input_width_sel}), 8'h1F);
        check("grey", 8'(st.border_grey_level), 8'h07);
        check("lower", 8'(st.lower_snr_limit), 8'h04);
        check("upper", 8'(st.upper_snr_limit), 8'h10);
        for (int c = 0; c < 8; c++) begin
            wr(8'h02, '{{3'(c), 5'h1F}, 8'h0, 8'h0, 8'h0}, 1);
            check("row", 8'(st.measure_row), rows[c]);
            check("upper", 8'(st.upper_snr_limit), 8'h1F);
        end
        for (int c = 0; c < 16; c++) begin
            wr(8'h03, '{{1'b1, 2'(c % 3), 1'b1, 4'(c)}, 8'h0, 8'h0, 8'h0}, 1);
            check("force", 8'({st.class_force_enable, st.forced_class,
                st.coef_force_enable}), 8'({1'b1, 2'(c % 3), 1'b1}));
            check("coef_k", 8'(st.forced_coef_k), kt[c]);
        end
        wr(8'h03, '{8'h00, 8'h0, 8'h0, 8'h0}, 1);
        check("auto", 8'({st.class_force_enable, st.coef_force_enable}),
            8'h00);
        mst.write(7'h16, 8'h00, '{8'h00, 8'h0, 8'h0, 8'h0}, 1, ok);
        check("bad ack", 8'(ok), 8'h00);
        check("bits", 8'(st.denoise_switch), 8'h01);
        $display("test registers done");

        wr(8'h00, '{8'h4F, 8'h0, 8'h0, 8'h0}, 1);
        check("op_mode", 8'(st.op_mode), 8'h00);
        n_field = 0;
        vs = 1'b1;
        tick(20);
        check("op_mode", 8'(st.op_mode), 8'h00);
        check("field", 8'(n_field), 8'h01);
        req = 1'b1;
        tick(10);
        check("op_mode", 8'(st.op_mode), 8'h01);
        {vs, req} = 2'b00;
        wr(8'h00, '{8'hCF, 8'h0, 8'h0, 8'h0}, 1);
        check("op_mode", 8'(st.op_mode), 8'h01);
        {vs, req} = 2'b11;
        tick(10);
        check("op_mode", 8'(st.op_mode), 8'h03);
        {vs, req} = 2'b00;
        wr(8'h00, '{8'h8F, 8'h0, 8'h0, 8'h0}, 1);
        check("op_mode", 8'(st.op_mode), 8'h02);
        wr(8'h00, '{8'h0F, 8'h0, 8'h0, 8'h0}, 1);
        check("op_mode", 8'(st.op_mode), 8'h00);
        $display("test op_mode done");

        blank_n = 1'b0;
        tick(20);
        n_line = 0;
        blank_n = 1'b1;
        tick(10);
        check("line", 8'(n_line), 8'h01);
        tick(800);
        check("nr first", 8'(nr), 8'h01);
        tick(2400);
        check("nr second", 8'(nr), 8'h00);
        fmt = 1'b1;
        tick(10);
        check("chroma", 8'(clv), 8'h01);
        fmt = 1'b0;
        n_in = 0;
        n_out = 0;
        tick(80);
        check("in ticks", 8'(n_in), 8'h0A);
        check("out ticks", 8'(n_out), 8'h0A);
        check("chroma", 8'(clv), 8'h00);
        wr(8'h00, '{8'h07, 8'h0, 8'h0, 8'h0}, 1);
        check("nr full", 8'(nr), 8'h01);
        wr(8'h00, '{8'h05, 8'h0, 8'h0, 8'h0}, 1);
        check("nr off", 8'(nr), 8'h00);
        $display("test pixels done");
        // mid-run reset with idle-high pins must not fake a line start
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(6);
        check("grey", 8'(st.border_grey_level), 8'h00);
        check("bits", 8'({st.tape_source_select, st.input_width_sel}),
            8'h00);
        check("line", 8'(n_line), 8'h01);
        check("sda out", 8'(sdo), 8'h00);
        $display("test rerun_reset done");
        print_verdict();
    end
endmodule

`default_nettype wire
